// >>> common/pmh_consts.svh
// Constants of the host serial port: offsets, field positions, reset values, counts.
// Assumes a 20 MHz i_mclk; included by the design modules and the bench.
//
// Overview of operation
// RQ1: Host holds reset low at least 1 us
// RQ2: Host waits 1 ms before first character
// RQ3: Characters are 8 data, no parity, 1 stop
// RQ4: Rates 600 to 115200 bps are selectable
// RQ5: 96-byte buffer; CTS high at two thirds
// RQ6: CTS low again below one third full
// RQ7: Host sends few characters after CTS high
// RQ8: Remote data goes to host on output line
// RQ9: Setup strap low at startup enters configurator
// RQ10: Fallback strap low at reset forces 9600 8n1
// RQ11: Sleep input high stops all traffic
// RQ12: Flow control is CTS or none
// RQ13: Host drives straps and sleep input itself
// RQ14: Reset aborts transfers and restarts everything
// RQ15: Host keeps sleep input low to operate
// RQ16: Bad stop bit character is discarded
// RQ17: Characters arriving when full are dropped
`ifndef PMH_CONSTS_SVH
`define PMH_CONSTS_SVH

`define PMH_CLK_HZ          20000000
`define PMH_DIV(b)          16'((`PMH_CLK_HZ + (b) / 2) / (b))

`define PMH_BUF_DEPTH       7'd96
`define PMH_CTS_SET_LVL     7'd64
`define PMH_CTS_CLR_LVL     7'd32

`define PMH_REG_CTRL        3'h0
`define PMH_REG_STATUS      3'h1
`define PMH_REG_LEVEL       3'h2
`define PMH_REG_HOSTDATA    3'h3
`define PMH_REG_REMOTEDATA  3'h4

`define PMH_CTRL_BAUD_LSB   0
`define PMH_CTRL_BAUD_MSB   3
`define PMH_CTRL_FLOW_BIT   4
`define PMH_CTRL_RST        8'h04
`define PMH_BAUD_9600_SEL   4'h4

`define PMH_STAT_CTS        0
`define PMH_STAT_CFG        1
`define PMH_STAT_FORCED     2
`define PMH_STAT_SLEEP      3
`define PMH_STAT_TXBUSY     4
`define PMH_STAT_AVAIL      5

`define PMH_STARTUP_CYCLES  2'h3
`define PMH_SYNC_RST        5'h0f

`endif

// >>> common/pmh_pkg.sv
// Types of the host serial port: states and the registered state records.
// Assumes pmh_consts.svh for all numeric constants.
package pmh_pkg;
    typedef enum logic [2:0] {
        PMH_INIT  = 3'b001,
        PMH_RUN   = 3'b010,
        PMH_SLEEP = 3'b100
    } pmh_mode_t;

    typedef enum logic [3:0] {
        PMH_RX_IDLE  = 4'b0001,
        PMH_RX_START = 4'b0010,
        PMH_RX_DATA  = 4'b0100,
        PMH_RX_STOP  = 4'b1000
    } pmh_rx_st_t;

    typedef struct packed {
        pmh_rx_st_t  st;
        logic [15:0] cnt;
        logic [2:0]  bitn;
        logic [7:0]  shreg;
        logic [7:0]  data;
        logic        valid;
        logic        ferr;
    } pmh_rx_t;

    typedef struct packed {
        logic [4:0]  s1;
        logic [4:0]  s2;
        pmh_mode_t   mode;
        logic [7:0]  ctrl;
        logic        cfg_mode;
        logic        forced;
        logic [1:0]  start_cnt;
        logic [6:0]  wr_ptr;
        logic [6:0]  rd_ptr;
        logic [6:0]  level;
        logic        cts;
        logic [7:0]  rdata;
        logic        tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bitn;
        logic [9:0]  tx_shreg;
        logic        txd;
    } pmh_state_t;
endpackage

// >>> common/pmh_rx_if.sv
// Link between the port top and its character receiver.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface pmh_rx_if;
    logic [15:0] div;
    logic        en;
    logic [7:0]  data;
    logic        valid;
    logic        ferr;
    modport top (output div, output en, input data, input valid, input ferr);
    modport rx  (input div, input en, output data, output valid, output ferr);
endinterface

// >>> logic/pmh_uart_rx.sv
// Receiver for host characters, 8n1, mid-bit sampling.
// Assumes the serial input is already synchronised to i_mclk.
`timescale 1ns/10ps
`include "pmh_consts.svh"
module pmh_uart_rx (
    input  wire logic i_mclk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_rxd,
    pmh_rx_if.rx      bus
);
    import pmh_pkg::*;

    pmh_rx_t st;
    pmh_rx_t next_st;

    assign bus.data  = st.data;
    assign bus.valid = st.valid;
    assign bus.ferr  = st.ferr;

    always_comb begin
        next_st       = st;
        next_st.valid = 1'b0;
        next_st.ferr  = 1'b0;
        if (st.cnt != 16'h0000) begin
            next_st.cnt = st.cnt - 16'h0001;
        end
        case (st.st)
            PMH_RX_IDLE: begin
                if (!i_rxd) begin
                    next_st.st  = PMH_RX_START;
                    next_st.cnt = {1'b0, bus.div[15:1]};
                end
            end
            PMH_RX_START: begin
                if (st.cnt == 16'h0000) begin
                    // A glitch shorter than half a bit is not a start bit
                    next_st.st   = i_rxd ? PMH_RX_IDLE : PMH_RX_DATA;
                    next_st.cnt  = bus.div - 16'h0001;
                    next_st.bitn = 3'h0;
                end
            end
            PMH_RX_DATA: begin
                if (st.cnt == 16'h0000) begin
                    next_st.shreg = {i_rxd, st.shreg[7:1]};            // [RQ3]
                    next_st.cnt   = bus.div - 16'h0001;
                    next_st.bitn  = st.bitn + 3'h1;
                    if (st.bitn == 3'h7) begin
                        next_st.st = PMH_RX_STOP;
                    end
                end
            end
            PMH_RX_STOP: begin
                if (st.cnt == 16'h0000) begin
                    next_st.st    = PMH_RX_IDLE;
                    next_st.data  = st.shreg;
                    next_st.valid = i_rxd;                              // [RQ16]
                    next_st.ferr  = !i_rxd;
                end
            end
            default: begin
                next_st.st = PMH_RX_IDLE;
            end
        endcase
        if (!bus.en) begin
            next_st.st    = PMH_RX_IDLE;                                // [RQ11] [RQ14]
            next_st.valid = 1'b0;
            next_st.ferr  = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st <= '{st: PMH_RX_IDLE, cnt: 16'h0000, bitn: 3'h0, shreg: 8'h00,
                    data: 8'h00, valid: 1'b0, ferr: 1'b0};
        end else if (i_ce) begin
            st <= next_st;
        end
    end
endmodule // pmh_uart_rx

// >>> logic/pmh_port.sv
// Host serial port of the packet modem: 96-byte host buffer, CTS throttle,
// character transmitter to the host, startup straps and sleep input.
// Assumes host pins are asynchronous and firmware uses the plain register port.
`timescale 1ns/10ps
`include "pmh_consts.svh"
module pmh_port (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_host_txd,
    input  wire logic       i_host_reset_n,
    input  wire logic       i_setup_n,
    input  wire logic       i_fallback_n,
    input  wire logic       i_sleep_req,
    output logic            o_host_rxd,
    output logic            o_cts,
    output logic            o_config_mode,
    output logic            o_sleeping
);
    import pmh_pkg::*;

    // Sync vector bit positions
    localparam int SY_TXD = 0;
    localparam int SY_RST = 1;
    localparam int SY_SET = 2;
    localparam int SY_DEF = 3;
    localparam int SY_WAK = 4;

    pmh_state_t st;
    pmh_state_t next_st;
    logic [7:0] mem [0:95];
    logic       push;
    logic       pop;
    pmh_rx_if   rxb ();

    function automatic logic [15:0] baud_div(input logic [3:0] sel);
        logic [15:0] d;
        d = `PMH_DIV(9600);
        case (sel)
            4'h0: d = `PMH_DIV(600);
            4'h1: d = `PMH_DIV(1200);
            4'h2: d = `PMH_DIV(2400);
            4'h3: d = `PMH_DIV(4800);
            4'h4: d = `PMH_DIV(9600);
            4'h5: d = `PMH_DIV(19200);
            4'h6: d = `PMH_DIV(38400);
            4'h7: d = `PMH_DIV(57600);
            4'h8: d = `PMH_DIV(115200);
            default: d = `PMH_DIV(9600);
        endcase
        return d;
    endfunction

    function automatic pmh_state_t reset_state(input logic [4:0] s1, input logic [4:0] s2);
        pmh_state_t r;
        r           = '0;
        r.s1        = s1;
        r.s2        = s2;
        r.mode      = PMH_INIT;
        r.ctrl      = `PMH_CTRL_RST;
        r.start_cnt = `PMH_STARTUP_CYCLES;
        r.tx_shreg  = 10'h3ff;
        r.txd       = 1'b1;
        return r;
    endfunction

    // Forced fallback overrides the stored rate
    assign rxb.div = st.forced ? baud_div(`PMH_BAUD_9600_SEL)                    // [RQ10]
                               : baud_div(st.ctrl[`PMH_CTRL_BAUD_MSB:`PMH_CTRL_BAUD_LSB]); // [RQ4]
    assign rxb.en  = st.mode[1] && st.s2[SY_RST] && !st.s2[SY_WAK];

    pmh_uart_rx u_rx (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_ce   (i_ce),
        .i_rxd  (st.s2[SY_TXD]),
        .bus    (rxb)
    );

    always_comb begin
        logic [6:0] lvl;
        lvl      = st.level;
        next_st  = st;
        push     = 1'b0;
        pop      = 1'b0;
        next_st.s1    = {i_sleep_req, i_fallback_n, i_setup_n, i_host_reset_n, i_host_txd};
        next_st.s2    = st.s1;
        next_st.rdata = 8'h00;

        case (st.mode)
            PMH_INIT: begin
                // Straps are read only after the synchronisers have filled
                if (st.start_cnt != 2'h0) begin
                    next_st.start_cnt = st.start_cnt - 2'h1;
                end else begin
                    next_st.cfg_mode = !st.s2[SY_SET];                  // [RQ9]
                    next_st.forced   = !st.s2[SY_DEF];                  // [RQ10]
                    next_st.mode     = PMH_RUN;
                end
            end
            PMH_RUN: begin
                if (st.s2[SY_WAK]) begin
                    next_st.mode = PMH_SLEEP;                           // [RQ11]
                end
            end
            PMH_SLEEP: begin
                if (!st.s2[SY_WAK]) begin
                    next_st.mode = PMH_RUN;
                end
            end
            default: begin
                next_st.mode = PMH_INIT;
            end
        endcase

        // Host character into buffer; a full buffer keeps its contents
        if (rxb.valid && st.mode[1]) begin
            if (st.level != `PMH_BUF_DEPTH) begin                       // [RQ17]
                push           = 1'b1;                                  // [RQ5]
                next_st.wr_ptr = (st.wr_ptr == `PMH_BUF_DEPTH - 7'd1) ? 7'd0 : st.wr_ptr + 7'd1;
            end
        end

        // Register reads
        if (i_rd) begin
            case (i_addr)
                `PMH_REG_CTRL: next_st.rdata = st.ctrl;
                `PMH_REG_STATUS: begin
                    next_st.rdata[`PMH_STAT_CTS]    = st.cts;
                    next_st.rdata[`PMH_STAT_CFG]    = st.cfg_mode;
                    next_st.rdata[`PMH_STAT_FORCED] = st.forced;
                    next_st.rdata[`PMH_STAT_SLEEP]  = st.mode[2];
                    next_st.rdata[`PMH_STAT_TXBUSY] = st.tx_busy;
                    next_st.rdata[`PMH_STAT_AVAIL]  = (st.level != 7'd0);
                end
                `PMH_REG_LEVEL: next_st.rdata = {1'b0, st.level};
                `PMH_REG_HOSTDATA: begin
                    if (st.level != 7'd0) begin
                        pop            = 1'b1;
                        next_st.rdata  = mem[st.rd_ptr];
                        next_st.rd_ptr = (st.rd_ptr == `PMH_BUF_DEPTH - 7'd1) ? 7'd0 : st.rd_ptr + 7'd1;
                    end
                end
                default: next_st.rdata = 8'h00;
            endcase
        end

        if (push && !pop) begin
            lvl = st.level + 7'd1;
        end else if (pop && !push) begin
            lvl = st.level - 7'd1;
        end
        next_st.level = lvl;

        // Hysteretic throttle, held low when handshake is off
        if (!st.ctrl[`PMH_CTRL_FLOW_BIT]) begin                         // [RQ12]
            next_st.cts = 1'b0;
        end else if (lvl >= `PMH_CTS_SET_LVL) begin
            next_st.cts = 1'b1;                                         // [RQ5]
        end else if (lvl < `PMH_CTS_CLR_LVL) begin
            next_st.cts = 1'b0;                                         // [RQ6]
        end

        // Register writes; a rate change applies from the next bit period, even within a character
        if (i_wr) begin
            case (i_addr)
                `PMH_REG_CTRL: next_st.ctrl = i_wdata;
                `PMH_REG_REMOTEDATA: begin
                    // Written while busy or asleep the character is dropped
                    if (!st.tx_busy && st.mode[1] && !st.s2[SY_WAK]) begin
                        next_st.tx_busy  = 1'b1;                        // [RQ8]
                        next_st.tx_shreg = {1'b1, i_wdata, 1'b0};       // [RQ3]
                        next_st.tx_bitn  = 4'h0;
                        next_st.tx_cnt   = 16'h0000;
                    end
                end
                default: begin
                end
            endcase
        end

        // Transmitter toward the host
        if (st.tx_busy) begin
            if (st.tx_cnt == 16'h0000) begin
                next_st.txd      = st.tx_shreg[0];
                next_st.tx_shreg = {1'b1, st.tx_shreg[9:1]};
                next_st.tx_cnt   = rxb.div - 16'h0001;
                next_st.tx_bitn  = st.tx_bitn + 4'h1;
                if (st.tx_bitn == 4'ha) begin
                    next_st.tx_busy = 1'b0;
                    next_st.txd     = 1'b1;
                end
            end else begin
                next_st.tx_cnt = st.tx_cnt - 16'h0001;
            end
        end
        if (st.s2[SY_WAK]) begin
            next_st.tx_busy = 1'b0;                                     // [RQ11]
            next_st.txd     = 1'b1;
        end

        // Host reset pin restarts everything but the synchronisers
        if (!st.s2[SY_RST]) begin
            next_st = reset_state(next_st.s1, next_st.s2);              // [RQ14]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st <= reset_state(`PMH_SYNC_RST, `PMH_SYNC_RST);            // [RQ14]
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // Buffer storage is kept outside the state record to stay a plain RAM
    always_ff @(posedge i_mclk) begin
        if (i_ce && push) begin
            mem[st.wr_ptr] <= rxb.data;
        end
    end

    assign o_rdata       = st.rdata;
    assign o_host_rxd    = st.txd;
    assign o_cts         = st.cts;
    assign o_config_mode = st.cfg_mode;
    assign o_sleeping    = st.mode[2];
endmodule // pmh_port

// >>> verification/pmh_port_chk.sv
// Pin-level checks of the host serial port.
// Assumes one clock domain, synchronous active-high i_rst and i_ce held high.
`timescale 1ns/10ps
module pmh_port_chk (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_host_txd,
    input wire logic i_host_reset_n,
    input wire logic i_setup_n,
    input wire logic i_sleep_req,
    input wire logic o_host_rxd,
    input wire logic o_cts,
    input wire logic o_config_mode,
    input wire logic o_sleeping
);
    logic [3:0] since_rst;

    // Cycles since the last restart, saturating; straps may only act early on
    always_ff @(posedge i_mclk) begin
        if (i_rst || !i_host_reset_n) begin
            since_rst <= 4'h0;
        end else if (i_ce && since_rst != 4'hf) begin
            since_rst <= since_rst + 4'h1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    chk_rst_outputs: assert property ($fell(i_rst) |-> !o_cts && o_host_rxd && !o_sleeping && !o_config_mode)
        else $error("outputs not at rest after reset");
    chk_host_restart: assert property ((!i_host_reset_n && i_ce) [*4] |=> !o_cts && o_host_rxd && !o_sleeping)
        else $error("host reset pin did not restart the port");
    chk_sleep_enter: assert property ((i_sleep_req && i_host_reset_n && i_ce) [*8] |-> o_sleeping)
        else $error("sleep request not obeyed");
    chk_sleep_exit: assert property ((!i_sleep_req && i_ce) [*8] |-> !o_sleeping)
        else $error("still asleep without request");
    chk_sleep_quiet: assert property (o_sleeping && $past(o_sleeping) |-> o_host_rxd)
        else $error("serial output active while asleep");
    chk_cfg_startup: assert property ($changed(o_config_mode) |-> since_rst < 4'd14)
        else $error("config mode changed outside startup");
    chk_cfg_capture: assert property (since_rst == 4'd14 && i_setup_n == $past(i_setup_n, 8)
        |-> o_config_mode == !i_setup_n)
        else $error("config mode does not follow strap");
    chk_cts_rise: assert property ($rose(o_cts) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_host_txd, 4))
        else $error("stop raised without a character or control write");
    chk_cts_fall: assert property (disable iff (i_rst || !i_host_reset_n)
        $fell(o_cts) |-> $past(i_rd) || $past(i_wr) || $past(i_wr, 2))
        else $error("stop cleared without a pop or control write");

    cov_cts_high: cover property ($rose(o_cts));
    cov_sleep: cover property ($rose(o_sleeping));
    cov_config: cover property ($rose(o_config_mode));
endmodule // pmh_port_chk

// >>> verification/pmh_host_model.sv
// Host side of the serial link: sends characters to the port and collects its output.
// Assumes i_div holds the bit period in clock cycles, set by the bench.
`timescale 1ns/10ps
module pmh_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_div,
    input  wire logic        i_rxd,
    output logic             o_txd
);
    logic [7:0] got[$];
    logic [7:0] sh;

    initial o_txd = 1'b1;

    // Start, eight bits LSB first, one stop; a low stop only when asked
    task automatic send(input logic [7:0] b, input logic stop_ok);
        logic [9:0] f;
        f = {stop_ok, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk);
            o_txd <= f[i];
            repeat (i_div - 16'd1) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_txd <= 1'b1;
    endtask

    // Mid-bit sampling; a bad stop bit is stored as unknown so it never matches
    always begin
        @(negedge i_rxd);
        repeat (i_div / 16'd2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (i_div) @(posedge i_clk);
            sh[i] = i_rxd;
        end
        repeat (i_div) @(posedge i_clk);
        got.push_back(i_rxd === 1'b1 ? sh : 8'hxx);
    end
endmodule // pmh_host_model

// >>> verification/pmh_port_bench.sv
// Self-checking bench of the host serial port: straps, rates, buffer and stop line, sleep, restart.
// Assumes the host model on the serial pins and the checker bound at the foot of this file.
`timescale 1ns/10ps
`include "pmh_consts.svh"
module pmh_port_bench;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_ce = 1'b1;
    logic [2:0]  i_addr = 3'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_host_reset_n = 1'b1;
    logic        i_setup_n = 1'b1;
    logic        i_fallback_n = 1'b1;
    logic        i_sleep_req = 1'b0; // Host keeps the port awake
    logic        i_host_txd;
    logic [7:0]  o_rdata;
    logic        o_host_rxd;
    logic        o_cts;
    logic        o_config_mode;
    logic        o_sleeping;
    logic [15:0] div = 16'd174;
    logic [31:0] seed = 32'hc177;
    logic [7:0]  q[$];
    logic [7:0]  v;
    logic        cts_e = 1'b0;
    int          bad_count = 0;
    int          compares = 0;

    always #25 i_mclk = ~i_mclk;

    pmh_port u_dut (.i_mclk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_host_txd,
        .i_host_reset_n, .i_setup_n, .i_fallback_n, .i_sleep_req, .o_host_rxd, .o_cts, .o_config_mode, .o_sleeping);
    pmh_host_model u_host (.i_clk(i_mclk), .i_div(div), .i_rxd(o_host_rxd), .o_txd(i_host_txd));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    function automatic logic [15:0] bit_div(input int baud);
        return 16'((20000000 + baud / 2) / baud);
    endfunction

    // Stop line hysteresis: set at two thirds, clear below one third
    function automatic logic cts_next(input int lvl, input logic prev);
        return lvl >= 64 ? 1'b1 : (lvl < 32 ? 1'b0 : prev);
    endfunction

    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string n);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
        check(n, v, e);
    endtask

    // Straps are driven by the host and held across the startup sample
    task automatic restart(input logic s, input logic f);
        @(posedge i_mclk);
        i_setup_n <= s;
        i_fallback_n <= f;
        i_rst <= 1'b1;
        tick(8);
        i_rst <= 1'b0;
        tick(20);
    endtask

    task automatic put(input logic [7:0] b);
        u_host.send(b, 1'b1);
        q.push_back(b);
        tick(4);
    endtask

    initial begin
        restart(1'b0, 1'b0);
        check("config", {7'h0, o_config_mode}, 8'h01);
        rchk(`PMH_REG_STATUS, 8'h06, "status straps low");
        rchk(`PMH_REG_STATUS, 8'h06, "status");
        check("forced", {7'h0, v[`PMH_STAT_FORCED]}, 8'h01);
        restart(1'b1, 1'b1);
        check("config", {7'h0, o_config_mode}, 8'h00);
        rchk(`PMH_REG_CTRL, 8'h04, "ctrl reset");
        rchk(3'h7, 8'h00, "unmapped");
        for (int s = 0; s < 9; s++) begin
            wreg(`PMH_REG_CTRL, 8'(s));
            rchk(`PMH_REG_CTRL, 8'(s), "baud sel");
        end
        tick(20000); // Host lets the port settle 1 ms before serial traffic
        wreg(`PMH_REG_CTRL, 8'h07);
        div = bit_div(57600);
        put(rnd());
        rchk(`PMH_REG_HOSTDATA, q.pop_front(), "char 57600");
        wreg(`PMH_REG_CTRL, 8'h18);
        div = bit_div(115200);
        u_host.send(rnd(), 1'b0);
        tick(4);
        rchk(`PMH_REG_LEVEL, 8'h00, "bad stop");
        // No further characters once stop is raised
        for (int n = 1; n <= 64; n++) begin
            put(n == 1 ? 8'hff : rnd());
            cts_e = cts_next(n, cts_e);
            check("cts fill", {7'h0, o_cts}, {7'h0, cts_e});
        end
        wreg(`PMH_REG_CTRL, 8'h08);
        tick(3);
        check("cts no flow", {7'h0, o_cts}, 8'h00);
        wreg(`PMH_REG_CTRL, 8'h18);
        tick(3);
        check("cts flow", {7'h0, o_cts}, 8'h01);
        for (int n = 63; n >= 0; n--) begin
            rchk(`PMH_REG_HOSTDATA, q.pop_front(), "hostdata");
            tick(3);
            cts_e = cts_next(n, cts_e);
            check("cts drain", {7'h0, o_cts}, {7'h0, cts_e});
        end
        for (int k = 0; k < 3; k++) begin
            q.push_back(k == 0 ? 8'h80 : rnd());
            wreg(`PMH_REG_REMOTEDATA, q[0]);
            rchk(`PMH_REG_STATUS, 8'h10, "status tx busy");
            tick(1776);
            check("to host", u_host.got.pop_front(), q.pop_front());
        end
        i_sleep_req <= 1'b1;
        tick(8);
        check("sleeping", {7'h0, o_sleeping}, 8'h01);
        wreg(`PMH_REG_REMOTEDATA, 8'h00);
        tick(5);
        check("line asleep", {7'h0, o_host_rxd}, 8'h01);
        u_host.send(rnd(), 1'b1);
        rchk(`PMH_REG_LEVEL, 8'h00, "level asleep");
        i_sleep_req <= 1'b0;
        tick(8);
        check("awake", {7'h0, o_sleeping}, 8'h00);
        put(rnd());
        wreg(`PMH_REG_REMOTEDATA, 8'h00);
        tick(100);
        i_host_reset_n <= 1'b0; // Held longer than 1 us
        tick(24);
        check("line restart", {7'h0, o_host_rxd}, 8'h01);
        i_host_reset_n <= 1'b1;
        tick(2000);
        rchk(`PMH_REG_CTRL, 8'h04, "ctrl restart");
        rchk(`PMH_REG_LEVEL, 8'h00, "level restart");
        print_verdict();
    end

    // Whole run needs about 150k cycles, mostly the buffer fill at the top rate; 175k means a hang
    initial begin
        tick(175000);
        check("watchdog", 8'h00, 8'h01);
        print_verdict();
    end
endmodule // pmh_port_bench

bind pmh_port pmh_port_chk u_chk (.i_mclk, .i_rst, .i_ce, .i_wr, .i_rd, .i_host_txd, .i_host_reset_n,
    .i_setup_n, .i_sleep_req, .o_host_rxd, .o_cts, .o_config_mode, .o_sleeping);
